// File: rtl/speed_select_pkg.sv
// Shared constants for the multi-speed selection block
package speed_select_pkg;
  // Table geometry
  localparam int ENTRY_COUNT = 16;
  localparam int INDEX_W = 4;
  localparam int FREQ_W = 16;
  localparam int TERM_COUNT = 5;
  localparam int FUNC_W = 8;
  // Terminal function codes for the index bits
  localparam logic [7:0] FUNC_INDEX_BIT0 = 8'h02;
  localparam logic [7:0] FUNC_INDEX_BIT1 = 8'h03;
  localparam logic [7:0] FUNC_INDEX_BIT2 = 8'h04;
  localparam logic [7:0] FUNC_INDEX_BIT3 = 8'h05;
  // Frequency source code selecting the speed table
  localparam logic [7:0] SOURCE_MULTI_SPEED = 8'h02;
  // Register offsets (word index = byte address / 4)
  localparam logic [7:0] OFF_SPEED_ENTRY_ZERO = 8'h00;
  localparam logic [7:0] OFF_SPEED_ENTRY_FIFTEEN = 8'h3C;
  localparam logic [7:0] OFF_MAX_FREQUENCY = 8'h40;
  localparam logic [7:0] OFF_SOURCE_SELECT = 8'h44;
  localparam logic [7:0] OFF_TERM_FUNC_1 = 8'h48;
  localparam logic [7:0] OFF_OUTPUT_SETTING = 8'h5C;
  localparam logic [7:0] OFF_STATUS = 8'h60;
  localparam logic [7:0] OFF_COMMANDED = 8'h64;
  // Reset values
  localparam logic [15:0] RESET_SPEED = 16'h0000;
  localparam logic [15:0] RESET_MAX_FREQUENCY = 16'h1770;
  localparam logic [7:0] RESET_SOURCE = 8'h02;
  localparam logic [7:0] RESET_TERM_FUNC = 8'h00;
  // Status field positions
  localparam int STAT_INDEX_LSB = 0;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_PEND_BIT = 5;
endpackage

// File: rtl/index_if.sv
// Carrier between terminal decoding and the speed table
interface index_if;
  logic [3:0] index; // Registered speed index
  logic valid; // Index is settled after sync

  modport source (output index, output valid);
  modport sink (input index, input valid);
endinterface

// File: rtl/speed_index_decode.sv
// Terminal synchroniser and function-based speed index decoder
module speed_index_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Terminals and their function assignments
  input wire logic [speed_select_pkg::TERM_COUNT-1:0] term,
  input wire logic [speed_select_pkg::TERM_COUNT*speed_select_pkg::FUNC_W-1:0] func_flat,
  // Decoded index
  index_if.source idx
);
  // Two-stage synchroniser per terminal
  logic [speed_select_pkg::TERM_COUNT-1:0] sync1_reg;
  logic [speed_select_pkg::TERM_COUNT-1:0] sync2_reg;
  logic [3:0] index_next;
  logic [3:0] index_reg;
  logic [1:0] settle_reg;

  // Bit of the index that a terminal function code drives
  function automatic logic [3:0] func_to_bit(input logic [7:0] code);
    logic [3:0] m;
    m = 4'h0;
    case (code)
      speed_select_pkg::FUNC_INDEX_BIT0: m = 4'h1;
      speed_select_pkg::FUNC_INDEX_BIT1: m = 4'h2;
      speed_select_pkg::FUNC_INDEX_BIT2: m = 4'h4;
      speed_select_pkg::FUNC_INDEX_BIT3: m = 4'h8;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  // Synchronise terminal levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= term;
      sync2_reg <= sync1_reg;
    end
  end

  // OR each active terminal into the bit its function names
  always_comb begin
    index_next = 4'h0; // Unassigned bits stay zero
    for (int i = 0; i < speed_select_pkg::TERM_COUNT; i++) begin
      if (sync2_reg[i]) begin
        index_next = index_next | func_to_bit(func_flat[i*8 +: 8]);
      end
    end
  end

  // One registered index so all bits move together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      index_reg <= 4'h0;
    end else begin
      index_reg <= index_next;
    end
  end

  // Valid once the pipeline has filled after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_reg <= 2'b00;
    end else if (settle_reg != 2'b11) begin
      settle_reg <= settle_reg + 2'b01;
    end
  end

  assign idx.index = index_reg;
  assign idx.valid = (settle_reg == 2'b11);
endmodule

// File: rtl/multi_speed_select.sv
// Multi-speed table, register port and commanded frequency output
// What this block does
// - Holds sixteen target frequencies for steady running
// - Function 02 terminal is index bit 0
// - Functions 03, 04 are index bits 1, 2
// - Function 05 terminal is index bit 3
// - Decode by function, not terminal position
// - Missing index bits read as zero
// - Index zero selects entry zero
// - Index change switches output frequency on the next clock
// - Edits commit only on store command
// - Output never exceeds maximum frequency setting, except one cycle after it is lowered
// - Entries form one contiguous sixteen-word block
// - Setting register edits selected entry while stopped
//
// Design decisions made here: the plain strobed port and the register offsets.
module multi_speed_select (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Input terminals
  input wire logic [speed_select_pkg::TERM_COUNT-1:0] TERM_IN,
  // Run state from the run/stop logic
  input wire logic RUN_MODE,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Commanded frequency
  output logic [speed_select_pkg::FREQ_W-1:0] FREQ_CMD,
  output logic FREQ_CMD_VALID
);
  localparam int FW = speed_select_pkg::FREQ_W;

  // Speed table
  logic [FW-1:0] speed_mem [speed_select_pkg::ENTRY_COUNT];
  // Configuration registers
  logic [FW-1:0] max_freq_reg;
  logic [7:0] source_reg;
  logic [7:0] term_func_reg [speed_select_pkg::TERM_COUNT];
  logic [speed_select_pkg::TERM_COUNT*8-1:0] func_flat;
  // Pending edit of the selected entry
  logic [FW-1:0] edit_reg;
  logic edit_pend_reg;
  // Read data and outputs
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [FW-1:0] freq_reg;
  logic [FW-1:0] freq_next;
  logic freq_valid_reg;
  logic store_hit;
  logic edit_hit;
  logic [3:0] sel;

  // Decoded index carrier
  index_if idx ();

  // Address-decoding helpers
  function automatic logic is_entry(input logic [7:0] a);
    return (a <= speed_select_pkg::OFF_SPEED_ENTRY_FIFTEEN) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_term(input logic [7:0] a);
    return (a >= speed_select_pkg::OFF_TERM_FUNC_1) && (a[1:0] == 2'b00) &&
      (a < speed_select_pkg::OFF_TERM_FUNC_1 + 8'(4 * speed_select_pkg::TERM_COUNT));
  endfunction

  // Clamp a frequency to the maximum setting
  function automatic logic [FW-1:0] clamp(input logic [FW-1:0] f, input logic [FW-1:0] m);
    return (f > m) ? m : f;
  endfunction

  // Flatten terminal functions for the decoder
  always_comb begin
    for (int i = 0; i < speed_select_pkg::TERM_COUNT; i++) begin
      func_flat[i*8 +: 8] = term_func_reg[i];
    end
  end

  // Terminal decoder
  speed_index_decode u_decode (
    .clk(CLK),
    .rst_n(RST_N),
    .term(TERM_IN),
    .func_flat(func_flat),
    .idx(idx.source)
  );

  assign sel = idx.index;

  // Write to the setting register edits, high bit 16 asks for a store
  assign edit_hit = REG_WR && (REG_ADDR == speed_select_pkg::OFF_OUTPUT_SETTING) && !RUN_MODE;
  assign store_hit = edit_hit && REG_WDATA[16];

  // Speed table writes: direct by offset, or store through the setting
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < speed_select_pkg::ENTRY_COUNT; i++) begin
        speed_mem[i] <= speed_select_pkg::RESET_SPEED;
      end
    end else if (REG_WR && is_entry(REG_ADDR)) begin
      speed_mem[REG_ADDR[5:2]] <= clamp(REG_WDATA[FW-1:0], max_freq_reg);
    end else if (store_hit) begin
      // Commit edit into the currently selected entry
      speed_mem[sel] <= clamp(REG_WDATA[FW-1:0], max_freq_reg);
    end
  end

  // Edit buffer holds uncommitted value
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      edit_reg <= speed_select_pkg::RESET_SPEED;
      edit_pend_reg <= 1'b0;
    end else if (store_hit) begin
      edit_reg <= REG_WDATA[FW-1:0];
      edit_pend_reg <= 1'b0;
    end else if (edit_hit) begin
      edit_reg <= REG_WDATA[FW-1:0]; // Edit only, table unchanged
      edit_pend_reg <= 1'b1;
    end else if (RUN_MODE) begin
      edit_pend_reg <= 1'b0; // Starting to run drops an uncommitted edit
    end
  end

  // Configuration registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      max_freq_reg <= speed_select_pkg::RESET_MAX_FREQUENCY;
      source_reg <= speed_select_pkg::RESET_SOURCE;
    end else if (REG_WR) begin
      if (REG_ADDR == speed_select_pkg::OFF_MAX_FREQUENCY) begin
        max_freq_reg <= REG_WDATA[FW-1:0];
      end
      if (REG_ADDR == speed_select_pkg::OFF_SOURCE_SELECT) begin
        source_reg <= REG_WDATA[7:0];
      end
    end
  end

  // Terminal function assignments
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < speed_select_pkg::TERM_COUNT; i++) begin
        term_func_reg[i] <= speed_select_pkg::RESET_TERM_FUNC;
      end
    end else if (REG_WR && is_term(REG_ADDR)) begin
      term_func_reg[3'((REG_ADDR - speed_select_pkg::OFF_TERM_FUNC_1) >> 2)] <=
        REG_WDATA[7:0];
    end
  end

  // Read multiplexer
  always_comb begin
    rdata_next = 32'h0000_0000; // Unmapped and reserved read zero
    if (is_entry(REG_ADDR)) begin
      rdata_next = {16'h0000, speed_mem[REG_ADDR[5:2]]};
    end else if (is_term(REG_ADDR)) begin
      rdata_next = {24'h00_0000,
        term_func_reg[3'((REG_ADDR - speed_select_pkg::OFF_TERM_FUNC_1) >> 2)]};
    end else begin
      case (REG_ADDR)
        speed_select_pkg::OFF_MAX_FREQUENCY: rdata_next = {16'h0000, max_freq_reg};
        speed_select_pkg::OFF_SOURCE_SELECT: rdata_next = {24'h00_0000, source_reg};
        speed_select_pkg::OFF_OUTPUT_SETTING: begin
          // Shows the pending edit, else the selected entry
          rdata_next = {16'h0000, edit_pend_reg ? edit_reg : speed_mem[sel]};
        end
        speed_select_pkg::OFF_STATUS: begin
          rdata_next[speed_select_pkg::STAT_INDEX_LSB +: 4] = sel;
          rdata_next[speed_select_pkg::STAT_RUN_BIT] = RUN_MODE;
          rdata_next[speed_select_pkg::STAT_PEND_BIT] = edit_pend_reg;
        end
        speed_select_pkg::OFF_COMMANDED: rdata_next = {16'h0000, freq_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (REG_RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Commanded frequency: selected entry, clamped
  always_comb begin
    if (source_reg == speed_select_pkg::SOURCE_MULTI_SPEED) begin
      freq_next = clamp(speed_mem[sel], max_freq_reg);
    end else begin
      freq_next = {FW{1'b0}};
    end
  end

  // Output register follows the index every cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      freq_reg <= speed_select_pkg::RESET_SPEED;
      freq_valid_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      freq_valid_reg <= idx.valid && (source_reg == speed_select_pkg::SOURCE_MULTI_SPEED);
    end
  end

  assign REG_RDATA = rdata_reg;
  assign FREQ_CMD = freq_reg;
  assign FREQ_CMD_VALID = freq_valid_reg;
endmodule

// File: dv/term_switches.sv
// Field switch model driving the input terminals
module term_switches (
  // Clock
  input wire logic CLK,
  // Requested contact states
  input wire logic [4:0] LEVELS,
  // Terminal lines, 1 = closed
  output logic [4:0] TERM_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle one clock after the request
  always_ff @(posedge CLK) begin
    TERM_IN <= LEVELS;
  end
endmodule

// File: dv/multi_speed_select_sva.sv
// Port checks for the multi-speed selection block
module multi_speed_select_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Inputs
  input wire logic [4:0] TERM_IN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  // Outputs
  input wire logic [31:0] REG_RDATA,
  input wire logic [15:0] FREQ_CMD,
  input wire logic FREQ_CMD_VALID
);
  logic [15:0] max_reg; // Shadow of the maximum setting
  logic [7:0] src_reg; // Shadow of the source select
  logic [4:0] term_reg; // Last terminal levels
  logic [3:0] quiet_reg; // Cycles since a possible cause of change
  // Track maximum and source writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      max_reg <= 16'h1770;
      src_reg <= 8'h02;
    end else if (REG_WR && REG_ADDR == 8'h40) begin
      max_reg <= REG_WDATA[15:0];
    end else if (REG_WR && REG_ADDR == 8'h44) begin
      src_reg <= REG_WDATA[7:0];
    end
  end
  // Count quiet cycles, saturating
  always_ff @(posedge CLK) begin
    term_reg <= TERM_IN;
    if (!RST_N || REG_WR || TERM_IN != term_reg) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence read_s(a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence src_off_s;
    (src_reg != 8'h02) [*2];
  endsequence
  rdata_idle_a: assert property (REG_RDATA != 32'h0 |-> $past(REG_RD))
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (read_s(8'h80) |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (REG_RDATA[31:17] == 15'h0)
    else $error("read data upper bits set");
  reset_valid_a: assert property ($rose(RST_N) |-> ##[1:4] FREQ_CMD_VALID)
    else $error("valid late after reset");
  clamp_max_a: assert property (max_reg == $past(max_reg, 3) |-> FREQ_CMD <= max_reg)
    else $error("frequency above maximum");
  freq_quiet_a: assert property (quiet_reg > 4'h6 |-> $stable(FREQ_CMD))
    else $error("frequency moved without cause");
  cmd_readback_a: assert property (read_s(8'h64) ##0 quiet_reg > 4'h6
    |=> REG_RDATA == {16'h0000, FREQ_CMD}) else $error("commanded readback wrong");
  source_off_a: assert property (src_off_s |=> FREQ_CMD == 16'h0 && !FREQ_CMD_VALID)
    else $error("output live with other source");
endmodule
bind multi_speed_select multi_speed_select_sva u_sva (.CLK(CLK), .RST_N(RST_N),
  .TERM_IN(TERM_IN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FREQ_CMD(FREQ_CMD),
  .FREQ_CMD_VALID(FREQ_CMD_VALID));

// File: dv/multi_speed_select_tb.sv
// Self-checking bench for the multi-speed selection block
module multi_speed_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // Bench clock
  logic rst_n = 1'b0; // Reset, active low
  logic run_mode = 1'b0; // Stopped at start
  logic [7:0] addr = 8'h00; // Register address
  logic [31:0] wdata = 32'h0000_0000; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [4:0] levels = 5'h00; // Requested contacts
  logic [4:0] term; // Terminal lines
  logic [31:0] rdata; // Read data
  logic [15:0] freq; // Commanded frequency
  logic freq_valid; // Commanded frequency valid
  logic [31:0] got; // Last read value
  int miscompares = 0; // Mismatches
  int comparisons = 0; // Comparisons made
  always #20 clk = ~clk;
  term_switches sw (.CLK(clk), .LEVELS(levels), .TERM_IN(term));
  multi_speed_select DUT (.CLK(clk), .RST_N(rst_n), .TERM_IN(term), .RUN_MODE(run_mode),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .FREQ_CMD(freq), .FREQ_CMD_VALID(freq_valid));
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Terminal 1 bit3, 2 bit2, 3 bit0, 4 bit1, 5 unused
  task automatic pick(input logic [3:0] i);
    @(posedge clk);
    levels <= {1'b0, i[1], i[0], i[2], i[3]};
    repeat (8) @(posedge clk);
  endtask
  // Counts and verdict
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(8'h40);
    check("max", 32'h0000_1770, got);
    reg_rd(8'h48);
    check("func1", 32'h0000_0000, got);
    for (int n = 0; n < 16; n++) begin
      reg_wr(8'(4 * n), 32'h0000_0100 + n);
    end
    reg_rd(8'h3C);
    check("entry15", 32'h0000_010F, got);
    reg_wr(8'h48, 32'h0000_0005);
    reg_wr(8'h4C, 32'h0000_0004);
    reg_wr(8'h50, 32'h0000_0002);
    reg_wr(8'h54, 32'h0000_0003);
    // Down to zero, so entry zero comes last
    for (int i = 15; i >= 0; i--) begin
      pick(4'(i));
      check("freq", 32'h0000_0100 + i, {16'h0000, freq});
      check("valid", 32'h0000_0001, {31'h0, freq_valid});
      reg_rd(8'h60);
      check("index", 32'(i), {28'h0, got[3:0]});
    end
    reg_wr(8'h48, 32'h0000_0000);
    pick(4'hF);
    check("freq", 32'h0000_0107, {16'h0000, freq});
    reg_wr(8'h40, 32'h0000_0104);
    pick(4'h6);
    check("freq", 32'h0000_0104, {16'h0000, freq});
    pick(4'h3);
    check("freq", 32'h0000_0103, {16'h0000, freq});
    reg_wr(8'h40, 32'h0000_1770);
    reg_wr(8'h5C, 32'h0000_0222);
    reg_rd(8'h0C);
    check("entry3", 32'h0000_0103, got);
    reg_rd(8'h5C);
    check("edit", 32'h0000_0222, got);
    reg_rd(8'h60);
    check("status", 32'h0000_0023, got);
    reg_wr(8'h5C, 32'h0001_0333);
    reg_rd(8'h0C);
    check("entry3", 32'h0000_0333, got);
    @(posedge clk);
    run_mode <= 1'b1;
    reg_wr(8'h5C, 32'h0001_0444);
    reg_rd(8'h0C);
    check("entry3", 32'h0000_0333, got);
    reg_rd(8'h60);
    check("status", 32'h0000_0013, got);
    @(posedge clk);
    run_mode <= 1'b0;
    repeat (8) @(posedge clk);
    reg_rd(8'h64);
    check("commanded", 32'h0000_0333, got);
    reg_wr(8'h44, 32'h0000_0000);
    repeat (4) @(posedge clk);
    check("freq off", 32'h0000_0000, {15'h0, freq_valid, freq});
    reg_wr(8'h44, 32'h0000_0002);
    reg_rd(8'h80);
    check("unmapped", 32'h0000_0000, got);
    tally_and_finish();
  end
endmodule
